// >>> logic/pdg_gpio.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - direction bit zero makes pin output
// - drive bit: 1 push-pull, 0 open-drain
// - input status follows pin in output mode
// - direction bit one makes pin input
// - filter on: level passes after 30 ms
// - filter off: changes pass without delay
// - debounce timed from dedicated oscillator
// - separate rise and fall edge events
// - rise mask one blocks rise interrupts, rise events still set
// - fall mask one blocks fall interrupts, fall events still set
// - both masks clear: every edge interrupts
// - readable alternate function bit per pin
// - pin 0 alternate: voltage scaling select input
// - pin 1 alternate: sequencer slot output
// - two pins, own config register each
// - irq low while unmasked event set
// - all masks set after reset
module pdg_gpio #(
  parameter int unsigned DEBOUNCE_TICKS = pdg_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // dedicated filter oscillator, sampled as a plain input
  input  wire logic       filt_osc_i,
  // register access port
  input  wire logic       cfg_wr_i,       // write strobe
  input  wire logic [1:0] cfg_sel_i,      // 0/1 pin config, 2 mask, 3 events
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg0_rdata_o,   // pin 0 config readback
  output logic      [7:0] cfg1_rdata_o,   // pin 1 config readback
  output logic      [1:0] mask_rdata_o,   // global_irq_mask_reg readback
  output logic      [3:0] event_o,        // {fall1,rise1,fall0,rise0}
  // pins, three signals each
  input  wire logic [1:0] pin_in_i,
  output logic      [1:0] pin_out_o,
  output logic      [1:0] pin_oe_o,
  // alternate function links
  input  wire logic       seq_slot_i,     // power_sequencer_slot, rail two
  output logic            vsel_o,         // voltage_scaling_select, rail zero
  // interrupt
  output logic            irq_out_n_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_s1_reg, pin_s1_next;    // first stage, read only by second
  logic [1:0] pin_s2_reg, pin_s2_next;    // settled pin level
  logic [2:0] osc_sync_reg, osc_sync_next; // two stages plus edge history

  // sync next values
  always_comb
  begin
    pin_s1_next   = pin_in_i;
    pin_s2_next   = pin_s1_reg;
    osc_sync_next = {osc_sync_reg[1:0], filt_osc_i};
  end

  // sync registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_reg   <= 2'h0;
      pin_s2_reg   <= 2'h0;
      osc_sync_reg <= 3'h0;
    end
    else
    begin
      pin_s1_reg   <= pin_s1_next;
      pin_s2_reg   <= pin_s2_next;
      osc_sync_reg <= osc_sync_next;
    end
  end

  // one tick per filter oscillator rising edge, seen only past stage two
  logic osc_tick;
  assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_reg  [2];
  logic [7:0] cfg_next [2];
  logic [1:0] mask_reg, mask_next;

  // software writes; status bit is never stored from the bus
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      cfg_next[i] = cfg_reg[i];
      if (cfg_wr_i && cfg_sel_i == 2'(i))
      begin
        cfg_next[i] = cfg_wdata_i & pdg_pkg::CFG_WR_MASK;
      end
    end
    mask_next = mask_reg;
    if (cfg_wr_i && cfg_sel_i == 2'h2)
    begin
      mask_next = cfg_wdata_i[1:0];
    end
  end

  // config registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_reg[0] <= pdg_pkg::CFG_RESET;
      cfg_reg[1] <= pdg_pkg::CFG_RESET;
      mask_reg   <= pdg_pkg::MSK_RESET;
    end
    else
    begin
      cfg_reg[0] <= cfg_next[0];
      cfg_reg[1] <= cfg_next[1];
      mask_reg   <= mask_next;
    end
  end

  // ---------------------------------------------------------------
  // debounce filter
  // ---------------------------------------------------------------
  // counting in oscillator ticks keeps the interval independent of mclk
  logic [1:0]  filt_reg, filt_next;       // filtered level per pin
  logic [15:0] dcnt_reg  [2];
  logic [15:0] dcnt_next [2];

  // filter next values
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      filt_next[i] = filt_reg[i];
      dcnt_next[i] = dcnt_reg[i];
      if (!cfg_reg[i][pdg_pkg::CFG_DBEN_BIT])
      begin
        filt_next[i] = pin_s2_reg[i];
        dcnt_next[i] = 16'h0000;
      end
      else if (pin_s2_reg[i] == filt_reg[i])
      begin
        dcnt_next[i] = 16'h0000;
      end
      else if (osc_tick)
      begin
        if (dcnt_next[i] >= 16'(DEBOUNCE_TICKS - 1))
        begin
          filt_next[i] = pin_s2_reg[i];
          dcnt_next[i] = 16'h0000;
        end
        else
        begin
          dcnt_next[i] = dcnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // filter registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      filt_reg    <= 2'h0;
      dcnt_reg[0] <= 16'h0000;
      dcnt_reg[1] <= 16'h0000;
    end
    else
    begin
      filt_reg    <= filt_next;
      dcnt_reg[0] <= dcnt_next[0];
      dcnt_reg[1] <= dcnt_next[1];
    end
  end

  // ---------------------------------------------------------------
  // edge events
  // ---------------------------------------------------------------
  logic [1:0] prev_reg, prev_next;        // filtered level one cycle back
  logic [3:0] evt_reg, evt_next;
  logic       irq_reg, irq_next;
  logic [2:0] arm_reg, arm_next;          // clocks since reset, saturating
  // edges stay blind until sync, filter and history hold real levels, else a
  // high pin against the zero reset value would raise a false rise event
  localparam logic [2:0] ARM_CYC = 3'h4;

  // events set by edges, cleared by writing ones to select 3
  always_comb
  begin
    prev_next = filt_reg;
    evt_next  = evt_reg;
    arm_next  = (arm_reg == ARM_CYC) ? arm_reg : arm_reg + 3'h1;
    if (cfg_wr_i && cfg_sel_i == 2'h3)
    begin
      evt_next = evt_reg & ~cfg_wdata_i[3:0];
    end
    for (int i = 0; i < 2; i++)
    begin
      // set after clear so a same-cycle edge is kept
      if (arm_reg == ARM_CYC && filt_reg[i] && !prev_reg[i])
      begin
        evt_next[2*i] = 1'b1;
      end
      if (arm_reg == ARM_CYC && !filt_reg[i] && prev_reg[i])
      begin
        evt_next[2*i+1] = 1'b1;
      end
    end
    // irq from unmasked events; both masks clear fires on every edge
    irq_next = ~(|(evt_next & {~mask_reg[pdg_pkg::MSK_FALL_BIT],
                               ~mask_reg[pdg_pkg::MSK_RISE_BIT],
                               ~mask_reg[pdg_pkg::MSK_FALL_BIT],
                               ~mask_reg[pdg_pkg::MSK_RISE_BIT]}));
  end

  // event registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_reg <= 2'h0;
      arm_reg  <= 3'h0;
      evt_reg  <= 4'h0;
      irq_reg  <= 1'b1;
    end
    else
    begin
      prev_reg <= prev_next;
      arm_reg  <= arm_next;
      evt_reg  <= evt_next;
      irq_reg  <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers and readback
  // ---------------------------------------------------------------
  logic [1:0] pout_reg, pout_next;
  logic [1:0] poe_reg, poe_next;
  logic       vsel_reg, vsel_next;
  logic [7:0] rd0_reg, rd0_next;
  logic [7:0] rd1_reg, rd1_next;

  // drive decisions per pin
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pout_next[i] = 1'b0;
      poe_next[i]  = 1'b0;
      if (i == 1 && cfg_reg[1][pdg_pkg::CFG_ALT_BIT])
      begin
        pout_next[i] = seq_slot_i;
        poe_next[i]  = 1'b1;
      end
      else if (i == 0 && cfg_reg[0][pdg_pkg::CFG_ALT_BIT])
      begin
        poe_next[i] = 1'b0;
      end
      else if (!cfg_reg[i][pdg_pkg::CFG_DIR_BIT])
      begin
        if (cfg_reg[i][pdg_pkg::CFG_DRV_BIT])
        begin
          pout_next[i] = cfg_reg[i][pdg_pkg::CFG_DO_BIT];
          poe_next[i]  = 1'b1;
        end
        else
        begin
          // open-drain only ever pulls low
          pout_next[i] = 1'b0;
          poe_next[i]  = ~cfg_reg[i][pdg_pkg::CFG_DO_BIT];
        end
      end
    end
    vsel_next = cfg_reg[0][pdg_pkg::CFG_ALT_BIT] & filt_reg[0];
    // status bit shows the real pin whatever the direction
    rd0_next = cfg_reg[0];
    rd0_next[pdg_pkg::CFG_DI_BIT] = pin_s2_reg[0];
    rd1_next = cfg_reg[1];
    rd1_next[pdg_pkg::CFG_DI_BIT] = pin_s2_reg[1];
  end

  // output registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pout_reg <= 2'h0;
      poe_reg  <= 2'h0;
      vsel_reg <= 1'b0;
      rd0_reg  <= pdg_pkg::CFG_RESET;
      rd1_reg  <= pdg_pkg::CFG_RESET;
    end
    else
    begin
      pout_reg <= pout_next;
      poe_reg  <= poe_next;
      vsel_reg <= vsel_next;
      rd0_reg  <= rd0_next;
      rd1_reg  <= rd1_next;
    end
  end

  // outputs, all straight from flops
  assign pin_out_o    = pout_reg;
  assign pin_oe_o     = poe_reg;
  assign vsel_o       = vsel_reg;
  assign cfg0_rdata_o = rd0_reg;
  assign cfg1_rdata_o = rd1_reg;
  assign mask_rdata_o = mask_reg;
  assign event_o      = evt_reg;
  assign irq_out_n_o  = irq_reg;

endmodule
`default_nettype wire

// >>> logic/pdg_pkg.sv
package pdg_pkg;
  // ---------------------------------------------------------------
  // pin_config_reg field positions
  // ---------------------------------------------------------------
  localparam int unsigned CFG_DIR_BIT   = 0;     // 1 = input, 0 = output
  localparam int unsigned CFG_DI_BIT    = 1;     // input level status (read only)
  localparam int unsigned CFG_DRV_BIT   = 2;     // 1 = push-pull, 0 = open-drain
  localparam int unsigned CFG_DO_BIT    = 3;     // output data level
  localparam int unsigned CFG_DBEN_BIT  = 4;     // input filter enable
  localparam int unsigned CFG_ALT_BIT   = 5;     // alternate function select
  localparam logic [7:0]  CFG_RESET     = 8'h01; // input, filter off, gpio mode
  localparam logic [7:0]  CFG_WR_MASK   = 8'h3d; // writable bits
  // ---------------------------------------------------------------
  // global_irq_mask_reg field positions
  // ---------------------------------------------------------------
  localparam int unsigned MSK_RISE_BIT  = 0;     // rise_edge_mask
  localparam int unsigned MSK_FALL_BIT  = 1;     // fall_edge_mask
  localparam logic [1:0]  MSK_RESET     = 2'h3;  // all masked after reset
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned DEBOUNCE_MS   = 30;    // debounce_interval
  localparam int unsigned FILT_CLK_KHZ  = 32;    // filter oscillator rate
  localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_MS * FILT_CLK_KHZ);
endpackage

// >>> sim/pdg_gpio_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// pin and irq checker
// ------------------------------------
module pdg_gpio_asserts #(
  parameter int unsigned DEBOUNCE_TICKS = 4
) (
  // clock, reset, writes
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       cfg_wr_i,
  input wire logic [1:0] cfg_sel_i,
  // readback
  input wire logic [7:0] cfg0_rdata_o,
  input wire logic [7:0] cfg1_rdata_o,
  input wire logic [1:0] mask_rdata_o,
  input wire logic [3:0] event_o,
  // pins and irq
  input wire logic [1:0] pin_out_o,
  input wire logic [1:0] pin_oe_o,
  input wire logic       seq_slot_i,
  input wire logic       irq_out_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_irq_cause: assert property (!irq_out_n_o |-> |event_o)
    else $error("irq low without event");
  chk_irq_unmask: assert property ($stable(mask_rdata_o) &&
    ((!mask_rdata_o[0] && (event_o[0] || event_o[2])) ||
     (!mask_rdata_o[1] && (event_o[1] || event_o[3]))) |-> !irq_out_n_o)
    else $error("unmasked event without irq");
  chk_irq_masked: assert property (mask_rdata_o == 2'h3 &&
    $past(mask_rdata_o) == 2'h3 |-> irq_out_n_o)
    else $error("irq with all masked");
  chk_pp_drive: assert property ($stable(cfg0_rdata_o[5:2]) &&
    cfg0_rdata_o[5:2] == 4'h1 && !cfg0_rdata_o[0] |-> pin_oe_o[0] && !pin_out_o[0])
    else $error("push-pull low wrong");
  chk_od_drive: assert property ($stable(cfg0_rdata_o[5:2]) &&
    !cfg0_rdata_o[5] && !cfg0_rdata_o[2] && !cfg0_rdata_o[0]
    |-> !pin_out_o[0] && pin_oe_o[0] == !cfg0_rdata_o[3])
    else $error("open-drain drive wrong");
  chk_in_float: assert property (cfg0_rdata_o[0] && $past(cfg0_rdata_o[0])
    |-> !pin_oe_o[0])
    else $error("input pin driven");
  chk_alt_slot: assert property (cfg1_rdata_o[5] && $past(cfg1_rdata_o[5])
    |-> pin_oe_o[1] && pin_out_o[1] == $past(seq_slot_i))
    else $error("slot output wrong");
  chk_ev_sticky: assert property ($fell(event_o[0])
    |-> $past(cfg_wr_i) && $past(cfg_sel_i) == 2'h3)
    else $error("event dropped without clear");
endmodule
bind pdg_gpio pdg_gpio_asserts #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) i_chk (.mclk_i, .rst_n_i,
  .cfg_wr_i, .cfg_sel_i, .cfg0_rdata_o, .cfg1_rdata_o, .mask_rdata_o, .event_o,
  .pin_out_o, .pin_oe_o, .seq_slot_i, .irq_out_n_o);
`default_nettype wire

// >>> sim/pdg_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// far side of the pins, pulled up
// ------------------------------------
module pdg_pins_model (
  // device drive
  input  wire logic [1:0] pin_out_i,
  input  wire logic [1:0] pin_oe_i,
  // outside driver
  input  wire logic [1:0] ext_en_i,
  input  wire logic [1:0] ext_val_i,
  // resolved wire
  output logic      [1:0] level_o
);
  // device low wins, released wire floats up to the pull-up
  always_comb
    for (int i = 0; i < 2; i++)
      level_o[i] = (pin_oe_i[i] && !pin_out_i[i]) ? 1'b0 :
                   pin_oe_i[i] ? 1'b1 : ext_en_i[i] ? ext_val_i[i] : 1'b1;
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// self-checking bench
// ------------------------------------
module tb;
  logic       mclk = 1'b0, rst_n = 1'b0, osc = 1'b0, wr = 1'b0, slot = 1'b0;
  logic [1:0] sel = 2'h0, ext_en = 2'h0, ext_val = 2'h0, pin_out, pin_oe, lvl, mask;
  logic [7:0] wdata = 8'h00, rd0, rd1;
  logic [3:0] ev;
  logic       vsel, irq_n;
  int         num_errors = 0, compares = 0, cycles = 0;
  // {write value, oe, out, readback}; top bits 6,7,1 must be ignored
  logic [17:0] rows [6] = '{{8'hce, 2'b11, 8'h0e}, {8'h44, 2'b10, 8'h04},
    {8'h88, 2'b00, 8'h0a}, {8'h00, 2'b10, 8'h00}, {8'h01, 2'b00, 8'h03},
    {8'hd5, 2'b00, 8'h17}};
  always #10 mclk = ~mclk;
  // filter oscillator, one tick every 8 clocks
  always #80 osc = ~osc;
  pdg_gpio #(.DEBOUNCE_TICKS(4)) i_pdg_gpio (.mclk_i(mclk), .rst_n_i(rst_n),
    .filt_osc_i(osc), .cfg_wr_i(wr), .cfg_sel_i(sel), .cfg_wdata_i(wdata),
    .cfg0_rdata_o(rd0), .cfg1_rdata_o(rd1), .mask_rdata_o(mask), .event_o(ev),
    .pin_in_i(lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .seq_slot_i(slot),
    .vsel_o(vsel), .irq_out_n_o(irq_n));
  pdg_pins_model i_pdg_pins_model (.pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    sel = s;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred clocks needed
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    cyc(16);
    cmp("cfg0", 8'h01, rd0);
    cmp("cfg1", 8'h01, rd1);
    cmp("mask", 8'h03, {6'h0, mask});
    cmp("irq", 8'h01, {7'h0, irq_n});
    rst_n = 1'b1;
    cyc(8);
    cmp("no edge", 8'h00, {4'h0, ev});
    for (int p = 0; p < 2; p++)
      foreach (rows[r])
      begin
        wr_reg(p[1:0], rows[r][17:10]);
        cyc(10);
        cmp("oe", {7'h0, rows[r][9]}, {7'h0, pin_oe[p]});
        cmp("out", {7'h0, rows[r][8]}, {7'h0, pin_out[p]});
        cmp("readback", rows[r][7:0], p ? rd1 : rd0);
      end
    cmp("cfg0 kept", 8'h17, rd0);
    // mask modes, filter off, pin0 driven from outside
    wr_reg(2'h0, 8'h01);
    ext_en = 2'h1;
    cyc(8);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(2'h2, m[7:0]);
      cmp("mask rd", m[7:0], {6'h0, mask});
      wr_reg(2'h3, 8'h0f);
      cyc(8);
      ext_val[0] = 1'b1;
      cyc(8);
      cmp("rise ev", 8'h01, {4'h0, ev});
      cmp("irq rise", {7'h0, m[0]}, {7'h0, irq_n});
      ext_val[0] = 1'b0;
      cyc(8);
      cmp("fall ev", 8'h03, {4'h0, ev});
      cmp("irq fall", {7'h0, m[0] & m[1]}, {7'h0, irq_n});
      wr_reg(2'h3, 8'h0f);
      cyc(2);
      cmp("cleared", 8'h10, {3'h0, irq_n, ev});
    end
    // debounce: short pulse lost, long level passes
    wr_reg(2'h0, 8'h11);
    wr_reg(2'h3, 8'h0f);
    ext_val[0] = 1'b1;
    cyc(16);
    ext_val[0] = 1'b0;
    cyc(48);
    cmp("glitch", 8'h00, {4'h0, ev});
    ext_val[0] = 1'b1;
    cyc(64);
    cmp("filtered", 8'h01, {4'h0, ev});
    // alternate functions
    wr_reg(2'h1, 8'h20);
    slot = 1'b1;
    cyc(4);
    cmp("slot", 8'h03, {6'h0, pin_oe[1], pin_out[1]});
    wr_reg(2'h0, 8'h21);
    cyc(8);
    cmp("vsel", 8'h01, {7'h0, vsel});
    cmp("alt bit", 8'h23, rd0);
    ext_val[0] = 1'b0;
    cyc(8);
    cmp("vsel low", 8'h00, {7'h0, vsel});
    // mid-run reset, pin0 held low and pin1 pulled up: no false edges
    rst_n = 1'b0;
    cyc(2);
    cmp("cfg0 rst", 8'h01, rd0);
    cmp("mask rst", 8'h03, {6'h0, mask});
    rst_n = 1'b1;
    cyc(8);
    cmp("no edge rst", 8'h00, {4'h0, ev});
    print_verdict();
  end
endmodule
`default_nettype wire
